// file: rtl/nand_host_seq.sv
// Module: host-side NAND command/address sequencer
`timescale 1ns/1ps
`default_nettype none
module nand_host_seq
  import nand_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // User request
  input  wire logic       req_valid_i,
  input  var  req_t       req_i,
  output logic            req_ready_o,
  // Write data stream
  input  wire logic       wdata_valid_i,
  input  wire logic [7:0] wdata_i,
  output logic            wdata_ready_o,
  // Read data stream
  output logic            rdata_valid_o,
  output logic [7:0]      rdata_o,
  // Completion
  output logic            done_o,
  output logic            fail_o,
  output logic            addr_error_o,
  // Memory pins
  output pins_t           pins_o,
  input  wire logic [7:0] io_in_i,
  input  wire logic       ready_busy_i
);

  typedef enum logic [3:0] {
    S_PWR, S_IDLE, S_CMD, S_ADDR, S_DATA, S_WAIT, S_POLL, S_STAT, S_DONE
  } st_t;

  typedef struct packed {
    st_t         st;
    logic        init_done;
    req_t        req;
    logic [3:0]  step;
    logic [2:0]  acnt;
    logic [7:0]  cmd;
    logic [11:0] dcnt;
    logic [1:0]  settle;
    logic [7:0]  rdata;
    logic [7:0]  io_cap;
    logic        rvalid;
    logic        done;
    logic        fail;
    logic        aerr;
  } core_t;

  core_t cur, next_cur;

  logic strobe_low;
  logic cyc_done;
  logic cyc_start;
  logic cyc_read;

  // ==========================================================================
  // Bus cycle engine
  nand_strobe_cycle u_cycle (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .start_i      (cyc_start),
    .is_read_i    (cyc_read),
    .strobe_low_o (strobe_low),
    .done_o       (cyc_done)
  );

  // ==========================================================================
  // Helpers: address byte selection and plane checks
  function automatic logic [7:0] addr_byte(input logic [15:0] col, input logic [23:0] row,
                                           input logic [2:0] idx, input logic with_col);
    logic [39:0] full;
    full = with_col ? {row, col} : {16'h0000, row};
    addr_byte = full[8*idx +: 8];
  endfunction

  function automatic logic blocks_pair(input logic [23:0] a, input logic [23:0] b);
    logic [23:0] m;
    m = 24'hFFFFFF;
    m[PLANE_SEL_POS] = 1'b0;
    blocks_pair = ((a & m) == (b & m)) && (a[PLANE_SEL_POS] != b[PLANE_SEL_POS]);
  endfunction

  // Column cycles present for this command
  function automatic logic has_col(input logic [7:0] c);
    has_col = (c == CMD_READ_SETUP) || (c == CMD_PROG_SETUP) ||
              (c == CMD_PROG_NEXT) || (c == CMD_CB_PROG);
  endfunction

  // Row used for this command step
  logic [23:0] cur_row;
  always_comb begin
    cur_row = cur.req.row_a;
    if (cur.cmd == CMD_CB_PROG || (cur.req.op == OP_CB && cur.cmd == CMD_PROG_NEXT)) begin
      cur_row = (cur.cmd == CMD_PROG_NEXT) ? cur.req.row_b : cur.req.row_dst;
    end else if (cur.cmd == CMD_PROG_NEXT || (cur.step != 4'h0 && cur.req.op == OP_ERASE)) begin
      cur_row = cur.req.row_b;
    end
  end

  // ==========================================================================
  // Sequence: next command byte for each operation and step
  function automatic logic [7:0] seq_cmd(input req_t r, input logic [3:0] s);
    seq_cmd = CMD_STATUS;
    unique case (r.op)
      OP_READ:  seq_cmd = (s == 4'h0) ? CMD_READ_SETUP : CMD_READ_CONFIRM;
      OP_PROG:  seq_cmd = (s == 4'h0) ? CMD_PROG_SETUP :
                          (s == 4'h1) ? (r.multiplane ? CMD_PROG_PLANE : CMD_PROG_CONFIRM) :
                          (s == 4'h2) ? CMD_PROG_NEXT : CMD_PROG_CONFIRM;
      OP_ERASE: seq_cmd = (s == 4'h0 || (s == 4'h1 && r.multiplane)) ? CMD_ERASE_SETUP :
                          CMD_ERASE_CONF;
      OP_CB:    seq_cmd = (s == 4'h0) ? CMD_READ_SETUP : (s == 4'h1) ? CMD_CB_READ :
                          (s == 4'h2) ? CMD_CB_PROG :
                          (s == 4'h3) ? (r.multiplane ? CMD_PROG_PLANE : CMD_PROG_CONFIRM) :
                          (s == 4'h4) ? CMD_PROG_NEXT : CMD_PROG_CONFIRM;
      OP_STATUS: seq_cmd = CMD_STATUS;
      OP_RESET:  seq_cmd = CMD_RESET;
      default:   seq_cmd = CMD_RESET;
    endcase
  endfunction

  // Number of address cycles after a command
  function automatic logic [2:0] addr_cycles(input logic [7:0] c);
    addr_cycles = 3'h0;
    if (has_col(c)) begin
      addr_cycles = 3'(COL_CYCLES + ROW_CYCLES);
    end else if (c == CMD_ERASE_SETUP) begin
      addr_cycles = 3'(ROW_CYCLES);
    end
  endfunction

  // Command starts a busy phase
  function automatic logic is_busy_cmd(input logic [7:0] c);
    is_busy_cmd = (c == CMD_READ_CONFIRM) || (c == CMD_PROG_CONFIRM) || (c == CMD_PROG_PLANE) ||
                  (c == CMD_ERASE_CONF) || (c == CMD_CB_READ) || (c == CMD_RESET) ||
                  (c == CMD_STATUS);
  endfunction

  // Last step of each operation
  function automatic logic [3:0] last_step(input req_t r);
    unique case (r.op)
      OP_READ:  last_step = 4'h1;
      OP_PROG:  last_step = r.multiplane ? 4'h3 : 4'h1;
      OP_ERASE: last_step = r.multiplane ? 4'h2 : 4'h1;
      OP_CB:    last_step = r.multiplane ? 4'h5 : 4'h3;
      default:  last_step = 4'h0;
    endcase
  endfunction

  // ==========================================================================
  // Main sequencer
  always_comb begin
    next_cur        = cur;
    next_cur.done   = 1'b0;
    next_cur.rvalid = 1'b0;
    // Bus is only valid while the read strobe is low
    if (strobe_low) next_cur.io_cap = io_in_i;
    cyc_start       = 1'b0;
    cyc_read        = 1'b0;
    wdata_ready_o   = 1'b0;
    req_ready_o     = (cur.st == S_IDLE);
    unique case (cur.st)
      S_PWR: begin
        // Wait for power-on busy time to end, then reset first
        if (ready_busy_i) begin
          next_cur.req.op = OP_RESET;
          next_cur.step   = 4'h0;
          next_cur.cmd    = CMD_RESET;
          next_cur.st     = S_CMD;
        end
      end
      S_IDLE: begin
        if (req_valid_i) begin
          next_cur.req  = req_i;
          next_cur.step = 4'h0;
          next_cur.fail = 1'b0;
          next_cur.aerr = 1'b0;
          next_cur.cmd  = seq_cmd(req_i, 4'h0);
          next_cur.st   = S_CMD;
          // Reject illegal plane pairings up front
          if ((req_i.multiplane && req_i.op inside {OP_PROG, OP_ERASE} &&
               !blocks_pair(req_i.row_a, req_i.row_b)) ||
              (req_i.op == OP_CB && (req_i.row_a[PLANE_SEL_POS] !=
               req_i.row_dst[PLANE_SEL_POS]))) begin
            next_cur.aerr = 1'b1;
            next_cur.st   = S_DONE;
          end
        end
      end
      S_CMD: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          next_cur.acnt = 3'h0;
          if (cur.cmd == CMD_READ_SETUP && cur.req.op == OP_READ && cur.step != 4'h0) begin
            next_cur.st = S_DATA;                           // Re-issued 00h
          end else if (addr_cycles(cur.cmd) != 3'h0) begin
            next_cur.st = S_ADDR;
          end else if (cur.cmd == CMD_STATUS) begin
            next_cur.st = S_STAT;
          end else if (is_busy_cmd(cur.cmd)) begin
            next_cur.settle = 2'(BUSY_SETTLE_CYC);
            next_cur.st     = S_WAIT;
          end else begin
            next_cur.st = S_DATA;                           // no issued command reaches this branch
          end
        end
      end
      S_ADDR: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          next_cur.acnt = cur.acnt + 3'h1;
          if (cur.acnt == addr_cycles(cur.cmd) - 3'h1) begin
            if (cur.cmd == CMD_PROG_SETUP || cur.cmd == CMD_PROG_NEXT) begin
              next_cur.dcnt = cur.req.data_len;
              next_cur.st   = S_DATA;
            end else begin
              next_cur.step = cur.step + 4'h1;
              next_cur.cmd  = seq_cmd(cur.req, cur.step + 4'h1);
              next_cur.st   = S_CMD;
            end
          end
        end
      end
      S_DATA: begin
        if (cur.req.op == OP_READ) begin
          cyc_start = 1'b1;
          cyc_read  = 1'b1;
          if (cyc_done) begin
            next_cur.rdata  = cur.io_cap;
            next_cur.rvalid = 1'b1;
            next_cur.dcnt   = cur.dcnt - 12'h1;
            if (cur.dcnt == 12'h1) begin
              next_cur.st = S_DONE;
            end
          end
        end else if (cur.dcnt == 12'h0) begin
          next_cur.step = cur.step + 4'h1;
          next_cur.cmd  = seq_cmd(cur.req, cur.step + 4'h1);
          next_cur.st   = S_CMD;
        end else begin
          // Back-pressure: a byte is taken only when its cycle ends
          cyc_start     = wdata_valid_i;
          wdata_ready_o = cyc_done;
          if (cyc_done) begin
            next_cur.dcnt = cur.dcnt - 12'h1;
          end
        end
      end
      S_WAIT: begin
        if (cur.settle != 2'h0) begin
          next_cur.settle = cur.settle - 2'h1;
        end else if (cur.cmd == CMD_RESET) begin
          if (ready_busy_i) begin
            next_cur.init_done = 1'b1;
            next_cur.st        = S_DONE;
          end
        end else begin
          // Poll status rather than trusting the busy line alone
          next_cur.cmd = CMD_STATUS;
          next_cur.st  = S_POLL;
        end
      end
      S_POLL: begin
        next_cur.st = S_CMD;                               // only 70h inside 11h..81h
      end
      S_STAT: begin
        cyc_start = 1'b1;
        cyc_read  = 1'b1;
        if (cyc_done) begin
          if (!cur.io_cap[STAT_READY_BIT]) begin
            next_cur.st = S_STAT;
          end else if (cur.req.op == OP_STATUS) begin
            next_cur.rdata  = cur.io_cap;
            next_cur.rvalid = 1'b1;
            next_cur.st     = S_DONE;
          end else if (cur.step >= last_step(cur.req)) begin
            if (cur.req.op == OP_READ) begin
              next_cur.cmd  = CMD_READ_SETUP;
              next_cur.dcnt = cur.req.data_len;
              next_cur.st   = S_CMD;
            end else begin
              next_cur.fail = cur.io_cap[STAT_FAIL_BIT];
              next_cur.st   = S_DONE;
            end
          end else begin
            next_cur.step = cur.step + 4'h1;
            next_cur.cmd  = seq_cmd(cur.req, cur.step + 4'h1);
            next_cur.st   = S_CMD;
          end
        end
      end
      S_DONE: begin
        next_cur.done = 1'b1;
        next_cur.st   = cur.init_done ? S_IDLE : S_PWR;
      end
    endcase
  end

  // ==========================================================================
  // Pin drive from registered state; io_out in S_DATA comes straight from wdata_i
  always_comb begin
    pins_o                = '0;
    pins_o.chip_sel_n     = (cur.st == S_IDLE) || (cur.st == S_PWR);
    pins_o.cmd_latch      = (cur.st == S_CMD);
    pins_o.addr_latch     = (cur.st == S_ADDR);
    pins_o.read_strobe_n  = !(strobe_low && (cur.st == S_STAT ||
                             (cur.st == S_DATA && cur.req.op == OP_READ)));
    pins_o.write_strobe_n = !(strobe_low && (cur.st == S_CMD || cur.st == S_ADDR ||
                             (cur.st == S_DATA && cur.req.op != OP_READ)));
    pins_o.write_prot_n   = cur.init_done;
    pins_o.io_oe_n        = !(cur.st == S_CMD || cur.st == S_ADDR ||
                             (cur.st == S_DATA && cur.req.op != OP_READ));
    unique case (cur.st)
      S_CMD:   pins_o.io_out = cur.cmd;
      S_ADDR:  pins_o.io_out = addr_byte(cur.req.col, cur_row, has_col(cur.cmd) ?
                               cur.acnt : cur.acnt + 3'(COL_CYCLES), 1'b1);
      S_DATA:  pins_o.io_out = wdata_i;
      default: pins_o.io_out = 8'h00;
    endcase
  end

  // Outputs from registers
  assign rdata_o       = cur.rdata;
  assign rdata_valid_o = cur.rvalid;
  assign done_o        = cur.done;
  assign fail_o        = cur.fail;
  assign addr_error_o  = cur.aerr;

  // State register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cur    <= '0;
      cur.st <= S_PWR;
    end else begin
      cur <= next_cur;
    end
  end

endmodule
`default_nettype wire

// file: rtl/nand_seq_pkg.sv
// Package: NAND host sequencer constants and carrier types
package nand_seq_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
  localparam logic [7:0] CMD_PROG_NEXT    = 8'h81;
  localparam logic [7:0] CMD_PROG_PLANE   = 8'h11;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;
  localparam logic [7:0] CMD_CB_READ      = 8'h35;
  localparam logic [7:0] CMD_CB_PROG      = 8'h85;
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH   = 8'h78;
  localparam logic [7:0] CMD_RESET        = 8'hFF;

  // ==========================================================================
  // Status register fields
  localparam int STAT_FAIL_BIT  = 0;
  localparam int STAT_READY_BIT = 6;

  // ==========================================================================
  // Address layout
  localparam int PLANE_SEL_POS = 6;
  localparam int COL_CYCLES    = 2;
  localparam int ROW_CYCLES    = 3;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 50;
  localparam int STROBE_LOW_NS       = 100;
  localparam int STROBE_HIGH_NS      = 100;
  localparam int BUSY_SETTLE_NS      = 100;
  localparam int STROBE_LOW_CYC   = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC  = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_SETTLE_CYC  = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Operation codes
  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_CB, OP_STATUS, OP_RESET
  } op_t;

  // Request bundle
  typedef struct packed {
    op_t         op;
    logic        multiplane;
    logic [15:0] col;
    logic [23:0] row_a;
    logic [23:0] row_b;
    logic [23:0] row_dst;
    logic [11:0] data_len;
  } req_t;

  // Pins toward the memory
  typedef struct packed {
    logic       chip_sel_n;
    logic       cmd_latch;
    logic       addr_latch;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       write_prot_n;
    logic [7:0] io_out;
    logic       io_oe_n;
  } pins_t;

endpackage

// file: rtl/nand_strobe_cycle.sv
// Module: one latched bus cycle on the NAND pins (write or read strobe)
`timescale 1ns/1ps
`default_nettype none
module nand_strobe_cycle
  import nand_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // Cycle request
  input  wire logic       start_i,
  input  wire logic       is_read_i,
  // Strobe and completion
  output logic            strobe_low_o,
  output logic            done_o
);

  typedef enum logic [1:0] {SC_IDLE, SC_LOW, SC_HIGH} sc_state_t;

  typedef struct packed {
    sc_state_t  st;
    logic [3:0] cnt;
    logic       rd;
  } sc_t;

  sc_t cur, next_cur;

  // ==========================================================================
  // Strobe timing: low phase then high recovery
  always_comb begin
    next_cur = cur;
    done_o   = 1'b0;
    unique case (cur.st)
      SC_IDLE: begin
        if (start_i) begin
          next_cur.st  = SC_LOW;
          next_cur.cnt = 4'(STROBE_LOW_CYC - 1);
          next_cur.rd  = is_read_i;
        end
      end
      SC_LOW: begin
        if (cur.cnt == 4'h0) begin
          next_cur.st  = SC_HIGH;                // Rising edge latches the byte
          next_cur.cnt = 4'(STROBE_HIGH_CYC - 1);
        end else begin
          next_cur.cnt = cur.cnt - 4'h1;
        end
      end
      SC_HIGH: begin
        if (cur.cnt == 4'h0) begin
          next_cur.st = SC_IDLE;
          done_o      = 1'b1;
        end else begin
          next_cur.cnt = cur.cnt - 4'h1;
        end
      end
    endcase
  end

  assign strobe_low_o = (cur.st == SC_LOW);

  // State register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cur <= '{st: SC_IDLE, cnt: 4'h0, rd: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

endmodule
`default_nettype wire

// file: testbench/nand_host_seq_chk.sv
// Concurrent protocol checks on the NAND host sequencer ports
`timescale 1ns/1ps
`default_nettype none
module nand_host_seq_chk
  import nand_seq_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // User side
  input  wire logic req_valid_i,
  input  var  req_t req_i,
  input  wire logic req_ready_o,
  input  wire logic done_o,
  input  wire logic addr_error_o,
  // Memory side
  input  var  pins_t pins_o
);
  // ==========================================================================
  // Bus byte decode
  logic       ws_q;
  logic       rs_q;
  logic       seen_cmd;
  logic       after_11;
  logic [7:0] last_cmd;
  logic [3:0] addr_cnt;
  logic       cmd_evt;
  logic       addr_evt;
  logic       rd_evt;
  logic       bad;

  // First cycle of a strobe low phase marks one byte
  assign cmd_evt  = !pins_o.write_strobe_n && ws_q && pins_o.cmd_latch;
  assign addr_evt = !pins_o.write_strobe_n && ws_q && pins_o.addr_latch;
  assign rd_evt   = !pins_o.read_strobe_n && rs_q && !pins_o.chip_sel_n;
  // Requests the design must refuse
  assign bad = (req_i.op == OP_CB) ?
      (req_i.row_a[PLANE_SEL_POS] != req_i.row_dst[PLANE_SEL_POS]) :
      (req_i.multiplane && (req_i.op == OP_PROG || req_i.op == OP_ERASE) &&
       ((((req_i.row_a ^ req_i.row_b) & ~(24'h000001 << PLANE_SEL_POS)) != 24'h000000) ||
        (req_i.row_a[PLANE_SEL_POS] == req_i.row_b[PLANE_SEL_POS])));

  // Command history; reset restarts power-on rule
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ws_q     <= 1'b1;
      rs_q     <= 1'b1;
      seen_cmd <= 1'b0;
      after_11 <= 1'b0;
      last_cmd <= 8'h00;
      addr_cnt <= 4'h0;
    end else begin
      ws_q <= pins_o.write_strobe_n;
      rs_q <= pins_o.read_strobe_n;
      if (cmd_evt) begin
        seen_cmd <= 1'b1;
        last_cmd <= pins_o.io_out;
        addr_cnt <= 4'h0;
        if (pins_o.io_out == 8'h11) after_11 <= 1'b1;
        else if (pins_o.io_out == 8'h81) after_11 <= 1'b0;
      end else if (addr_evt) begin
        addr_cnt <= addr_cnt + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence strobe_low;  !pins_o.write_strobe_n [*2]; endsequence
  sequence strobe_high; pins_o.write_strobe_n [*2];  endsequence

  AST_CMD_PINS: assert property (cmd_evt |-> !pins_o.chip_sel_n && !pins_o.addr_latch &&
      pins_o.read_strobe_n && !pins_o.io_oe_n) else $error("command byte pin levels wrong");
  AST_ADDR_PINS: assert property (!pins_o.write_strobe_n && pins_o.addr_latch |->
      !pins_o.chip_sel_n && !pins_o.cmd_latch && pins_o.read_strobe_n)
    else $error("address byte pin levels wrong");
  AST_STROBE_SHAPE: assert property ($fell(pins_o.write_strobe_n) |->
      strobe_low ##1 strobe_high) else $error("write strobe phase length wrong");
  AST_WP_MODIFY: assert property (cmd_evt &&
      (pins_o.io_out inside {8'h80, 8'h81, 8'h60, 8'h85}) |-> pins_o.write_prot_n)
    else $error("write protect low on modify command");
  AST_PLANE_GAP: assert property (cmd_evt && after_11 |->
      (pins_o.io_out inside {8'h70, 8'h78, 8'hFF, 8'h81})) else $error("illegal command after 11h");
  AST_FIRST_RESET: assert property (cmd_evt && !seen_cmd |-> pins_o.io_out == 8'hFF)
    else $error("first command not reset");
  AST_READ_AFTER: assert property (rd_evt |-> (last_cmd inside {8'h70, 8'h78, 8'h00}))
    else $error("data read without read command");
  AST_ADDR_COUNT: assert property (cmd_evt && (last_cmd inside {8'h60, 8'h80, 8'h81, 8'h85}) |->
      addr_cnt == ((last_cmd == 8'h60) ? 4'h3 : 4'h5)) else $error("address cycle count wrong");
  AST_REFUSE: assert property (req_valid_i && req_ready_o && bad |->
      pins_o.write_strobe_n throughout ##2 (done_o && addr_error_o))
    else $error("bad plane request not refused");
endmodule
`default_nettype wire

bind nand_host_seq nand_host_seq_chk nand_host_seq_chk_i (.*);

// file: testbench/nand_dev_model.sv
// Behavioural NAND memory answering the host sequencer pins
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model
  import nand_seq_pkg::*;
#(
  parameter int PWRUP_CYC = 40,
  parameter int BUSY_CYC  = 12
)(
  // Pins from the host
  input  wire logic       core_clk_i,
  input  var  pins_t      pins_i,
  input  wire logic       fail_inj_i,
  // Pins toward the host
  output logic [7:0]      io_o,
  output logic            ready_busy_o
);
  logic [8:0] log_q[$];
  int         busy_cnt = PWRUP_CYC;
  int         wr_cnt   = 0;
  int         addr_n   = 0;
  logic [7:0] rd_idx   = 8'h00;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] io_q     = 8'h00;
  logic [7:0] io_last  = 8'h00;
  logic       fail_q   = 1'b0;
  logic       plane_q  = 1'b0;
  logic       cs_q     = 1'b1;
  logic       ws_q     = 1'b1;
  logic       rs_q     = 1'b1;
  logic       cl_q     = 1'b0;
  logic       al_q     = 1'b0;

  // Released bus shows the inverse of the last byte, never a stale copy
  assign ready_busy_o = (busy_cnt == 0);
  assign io_o = (!pins_i.chip_sel_n && !pins_i.read_strobe_n) ?
      ((last_cmd inside {8'h70, 8'h78}) ? {1'b0, ready_busy_o, 5'h00, fail_q} :
       8'hA5 + rd_idx) : ~io_last;

  // Bytes are taken on the rising write strobe with levels held in its low phase
  always @(posedge core_clk_i) begin
    busy_cnt <= (busy_cnt > 0) ? busy_cnt - 1 : 0;
    if (!cs_q && !ws_q && pins_i.write_strobe_n && rs_q) begin
      if (cl_q && !al_q) begin
        last_cmd <= io_q;
        addr_n   <= 0;
        rd_idx   <= 8'h00;
        if (!(io_q inside {8'h70, 8'h78})) log_q.push_back({1'b1, io_q});
        if (io_q inside {8'h10, 8'h11, 8'h30, 8'h35, 8'hD0, 8'hFF}) begin
          busy_cnt <= BUSY_CYC;
          fail_q   <= fail_inj_i;
        end
      end else if (al_q && !cl_q) begin
        log_q.push_back({1'b0, io_q});
        addr_n <= addr_n + 1;
        if (addr_n == ((last_cmd == 8'h60) ? 0 : 2)) plane_q <= io_q[PLANE_SEL_POS];
      end else begin
        wr_cnt <= wr_cnt + 1;
      end
    end
    if (!cs_q && !rs_q && pins_i.read_strobe_n && !(last_cmd inside {8'h70, 8'h78}))
      rd_idx <= rd_idx + 8'h01;
    if (!pins_i.read_strobe_n) io_last <= io_o;
    cs_q <= pins_i.chip_sel_n;
    ws_q <= pins_i.write_strobe_n;
    rs_q <= pins_i.read_strobe_n;
    cl_q <= pins_i.cmd_latch;
    al_q <= pins_i.addr_latch;
    io_q <= pins_i.io_out;
  end
endmodule
`default_nettype wire

// file: testbench/nand_host_seq_bench.sv
// Self-checking bench for the NAND host sequencer against a memory model
`timescale 1ns/1ps
`default_nettype none
module nand_host_seq_bench;
  import nand_seq_pkg::*;
  // ==========================================================================
  // Signals
  logic       core_clk_i    = 1'b0;
  logic       rst_n_i       = 1'b0;
  logic       req_valid_i   = 1'b0;
  req_t       req_i         = '0;
  logic       wdata_valid_i = 1'b0;
  logic [7:0] wdata_i       = 8'h00;
  logic       fail_inj      = 1'b0;
  logic       req_ready_o, wdata_ready_o, rdata_valid_o, done_o, fail_o, addr_error_o;
  logic       ready_busy_i;
  logic [7:0] rdata_o;
  logic [7:0] io_in_i;
  pins_t      pins_o;
  logic [8:0] exp_q[$];
  logic [7:0] rd_q[$];
  int         fails         = 0;
  int         cmp_count     = 0;

  nand_host_seq nand_host_seq_i (.*);
  nand_dev_model nand_dev_model_i (.core_clk_i(core_clk_i), .pins_i(pins_o),
    .fail_inj_i(fail_inj), .io_o(io_in_i), .ready_busy_o(ready_busy_i));

  // ==========================================================================
  // Clock, write stream and read capture
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (wdata_ready_o === 1'b1) wdata_i <= wdata_i + 8'h01;
    if (rdata_valid_o === 1'b1) rd_q.push_back(rdata_o);
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait; looks mid-cycle where outputs are settled
  task automatic tick(inout int n);
    @(negedge core_clk_i);
    n++;
    if (n > 4000) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    exp_q.push_back({1'b1, b});
  endtask
  // Expected address bytes, low byte first
  task automatic adr(input logic [15:0] c, input logic [23:0] r, input logic with_col);
    if (with_col) for (int i = 0; i < 2; i++) exp_q.push_back({1'b0, c[8*i +: 8]});
    for (int i = 0; i < 3; i++) exp_q.push_back({1'b0, r[8*i +: 8]});
  endtask
  task automatic check_log();
    check("log length", nand_dev_model_i.log_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < nand_dev_model_i.log_q.size())
      check("bus byte", nand_dev_model_i.log_q[i], exp_q[i]);
    exp_q.delete();
  endtask
  function automatic req_t mk(op_t op, logic mp, logic [15:0] c, logic [23:0] a,
                              logic [23:0] b, logic [23:0] d, logic [11:0] n);
    mk = '{op, mp, c, a, b, d, n};
  endfunction
  // One request: held until taken, then waited on until done
  task automatic run(input req_t r);
    int n = 0;
    nand_dev_model_i.log_q.delete();
    rd_q.delete();
    @(posedge core_clk_i);
    req_i       <= r;
    req_valid_i <= 1'b1;
    do tick(n); while (req_ready_o !== 1'b1);
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    do tick(n); while (done_o !== 1'b1);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_init();
    int n = 0;
    cmd(8'hFF);
    do tick(n); while (done_o !== 1'b1);
    check_log();
  endtask
  task automatic t_prog();
    cmd(8'h80); adr(16'h0123, 24'h0456A9, 1'b1); cmd(8'h10);
    run(mk(OP_PROG, 1'b0, 16'h0123, 24'h0456A9, 24'h000000, 24'h000000, 12'h004));
    check_log();
    check("data bytes", nand_dev_model_i.wr_cnt, 4);
    check("fail flag", fail_o, 1'b0);
  endtask
  task automatic t_mp_prog();
    cmd(8'h80); adr(16'h0040, 24'h012380, 1'b1); cmd(8'h11);
    cmd(8'h81); adr(16'h0040, 24'h0123C0, 1'b1); cmd(8'h10);
    run(mk(OP_PROG, 1'b1, 16'h0040, 24'h012380, 24'h0123C0, 24'h000000, 12'h002));
    check_log();
    check("plane", nand_dev_model_i.plane_q, 1'b1);
  endtask
  task automatic t_erase_fail();
    fail_inj <= 1'b1;
    cmd(8'h60); adr(16'h0000, 24'h000200, 1'b0);
    cmd(8'h60); adr(16'h0000, 24'h000240, 1'b0); cmd(8'hD0);
    run(mk(OP_ERASE, 1'b1, 16'h0000, 24'h000200, 24'h000240, 24'h000000, 12'h000));
    check_log();
    check("fail flag", fail_o, 1'b1);
    fail_inj <= 1'b0;
  endtask
  task automatic t_read();
    cmd(8'h00); adr(16'h0010, 24'h000081, 1'b1); cmd(8'h30); cmd(8'h00);
    run(mk(OP_READ, 1'b0, 16'h0010, 24'h000081, 24'h000000, 24'h000000, 12'h003));
    check_log();
    check("read count", rd_q.size() >= 3, 1'b1);
    if (rd_q.size() >= 3) for (int i = 0; i < 3; i++)
      check("read byte", rd_q[rd_q.size() - 3 + i], 8'hA5 + i);
  endtask
  task automatic t_copyback();
    cmd(8'h00); adr(16'h0008, 24'h000305, 1'b1); cmd(8'h35);
    cmd(8'h85); adr(16'h0008, 24'h000311, 1'b1); cmd(8'h10);
    run(mk(OP_CB, 1'b0, 16'h0008, 24'h000305, 24'h000000, 24'h000311, 12'h000));
    check_log();
  endtask
  // Block bits that differ, then a copy back that leaves its plane
  task automatic t_refuse();
    run(mk(OP_ERASE, 1'b1, 16'h0000, 24'h000200, 24'h000640, 24'h000000, 12'h000));
    check("refused", addr_error_o, 1'b1);
    check_log();
    run(mk(OP_CB, 1'b0, 16'h0000, 24'h000305, 24'h000000, 24'h000345, 12'h000));
    check("refused", addr_error_o, 1'b1);
    check_log();
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i       <= 1'b1;
    wdata_valid_i <= 1'b1;
    t_init();
    t_prog();
    t_mp_prog();
    t_erase_fail();
    t_read();
    t_copyback();
    t_refuse();
    wrap_up();
  end
endmodule
`default_nettype wire
